// >>> verilog/adsc_ctrl.sv
// accessory detect and switch control: detection, type record, switch drive
// assumes comparator/adc results and decoded host writes are synchronous to i_mclk
`timescale 1ns/1ps
// Summary of operation
// - detects inserted accessory on its own and classifies its type
// - stores the classified type in a host-readable register output
// - in auto mode switches follow the detection result
// - manual mode lets host choose open and closed switches
// - standby after power-up and whenever nothing is attached
// - standby watches bus-power and id comparators for insertion
// - detection enabled by battery or bus supply, battery preferred
// - i2c enabled only with io rail and battery present
// - no battery and no bus holds power-down reset
// - bus power high and not charger measures id impedance
// - bus power low with attach uses adc on id line
// - both i2c lines low over 30 ms resets digital logic
// - after soft reset irq_out_n stays low until mask cleared
// - power-on reset release sets registers and detection state machine to default
module adsc_ctrl #(
   parameter int SWRST_CYCLES = adsc_pkg::SWRST_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_bat_ok,
   input wire logic i_bus_ok,
   input wire logic i_io_rail_supply,
   input wire logic i_vbus_cmp,
   input wire logic i_id_cmp,
   input wire logic i_chg_det,
   input wire logic i_adc_valid,
   input wire logic [adsc_pkg::ADC_W-1:0] i_adc_code,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_ack,
   input wire logic i_man_wr,
   input wire logic i_man_mode,
   input wire logic [1:0] i_man_sw,
   input wire logic i_mask_clr,
   output logic [adsc_pkg::TYPE_W-1:0] o_acc_type,
   output logic [adsc_pkg::ADC_W-1:0] o_adc_reg,
   output logic [1:0] o_sw_close,
   output logic o_adc_start,
   output logic o_i2c_en,
   output logic o_det_en,
   output logic o_supply_bat,
   output logic o_irq_out_n,
   output logic o_soft_rst
);
   import adsc_pkg::*;

   logic [1:0] rsync_r;
   logic rst_b;
   logic pwr_ok;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) rsync_r <= 2'h0;
      else rsync_r <= {rsync_r[0], 1'b1};
   end
   assign pwr_ok = i_bat_ok | i_bus_ok;
   assign rst_b = rsync_r[1];

   function automatic logic [TYPE_W-1:0] adsc_classify(input logic [ADC_W-1:0] c);
      unique case (c)
         ADC_OTG: adsc_classify = TY_OTG;
         ADC_UART, ADC_PPD: adsc_classify = TY_UART;
         ADC_FUSB0, ADC_FUSB1: adsc_classify = TY_FUSB;
         ADC_FUART0, ADC_FUART1: adsc_classify = TY_FUART;
         default: adsc_classify = TY_OTHER;
      endcase
   endfunction

   function automatic logic [1:0] adsc_sw_of(input logic [TYPE_W-1:0] t);
      unique case (t)
         TY_USB, TY_FUSB, TY_OTG: adsc_sw_of = SW_USB;
         TY_UART, TY_FUART: adsc_sw_of = SW_UART;
         default: adsc_sw_of = 2'h0;
      endcase
   endfunction

   adsc_state_t st_r, st_nxt;
   logic [TYPE_W-1:0] type_r, type_nxt;
   logic [ADC_W-1:0] adc_r, adc_nxt;
   logic [1:0] sw_r, sw_nxt, man_r, man_nxt, tgt;
   logic mode_r, mode_nxt, mask_r, mask_nxt;
   logic [31:0] sr_cnt_r, sr_cnt_nxt;
   logic [31:0] dly_r, dly_nxt;
   logic soft_r, soft_nxt;
   logic attach, i2c_ok, hard_clr;

   assign i2c_ok = i_io_rail_supply & i_bat_ok;
   assign attach = i_vbus_cmp | i_id_cmp;
   assign hard_clr = soft_r | ~pwr_ok;

   always_comb begin
      st_nxt = st_r;
      type_nxt = type_r;
      adc_nxt = adc_r;
      man_nxt = man_r;
      mode_nxt = mode_r;
      mask_nxt = mask_r;
      sr_cnt_nxt = 32'h0;
      soft_nxt = 1'b0;
      if (i2c_ok && !i_scl && !i_sda) begin
         sr_cnt_nxt = sr_cnt_r + 32'h1;
         if (sr_cnt_r == 32'(SWRST_CYCLES - 1)) soft_nxt = 1'b1;
      end
      if (i2c_ok && i_man_wr) begin
         man_nxt = i_man_sw;
         mode_nxt = i_man_mode;
      end
      if (i2c_ok && i_mask_clr) mask_nxt = 1'b0;
      unique case (st_r)
         ST_STBY: begin
            if (attach) st_nxt = ST_MEAS;
         end
         ST_MEAS: begin
            if (!attach) st_nxt = ST_STBY;
            else if (i_vbus_cmp && i_chg_det) begin
               type_nxt = TY_CHG;
               st_nxt = ST_ATT;
            end else if (i_adc_valid) begin
               adc_nxt = i_adc_code;
               if (i_adc_code == ADC_NONE && i_vbus_cmp) type_nxt = TY_USB;
               else type_nxt = adsc_classify(i_adc_code);
               st_nxt = ST_ATT;
            end
         end
         ST_ATT: begin
            if (!attach) begin
               st_nxt = ST_STBY;
               type_nxt = TY_NONE;
               adc_nxt = ADC_NONE;
            end
         end
         default: st_nxt = ST_STBY;
      endcase
      if (hard_clr) begin
         st_nxt = ST_STBY;
         type_nxt = TY_NONE;
         adc_nxt = ADC_NONE;
         man_nxt = 2'h0;
         mode_nxt = 1'b0;
         mask_nxt = soft_r;
         sr_cnt_nxt = 32'h0;
         soft_nxt = 1'b0;
      end
   end

   assign tgt = mode_r ? man_r : adsc_sw_of(type_r);

   always_comb begin
      sw_nxt = sw_r;
      dly_nxt = 32'h0;
      if (tgt != sw_r) begin
         dly_nxt = dly_r + 32'h1;
         if ((|(sw_r & ~tgt) && dly_r >= 32'(TOFF_CYC - 1))
             || dly_r >= 32'(TON_CYC - 1)) begin
            sw_nxt = tgt;
            dly_nxt = 32'h0;
         end
      end
      if (hard_clr) begin
         sw_nxt = 2'h0;
         dly_nxt = 32'h0;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_STBY;
         type_r <= TY_NONE;
         adc_r <= ADC_NONE;
         man_r <= 2'h0;
         mode_r <= 1'b0;
         mask_r <= 1'b0;
         sr_cnt_r <= 32'h0;
         dly_r <= 32'h0;
         soft_r <= 1'b0;
         sw_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         type_r <= type_nxt;
         adc_r <= adc_nxt;
         man_r <= man_nxt;
         mode_r <= mode_nxt;
         mask_r <= mask_nxt;
         sr_cnt_r <= sr_cnt_nxt;
         dly_r <= dly_nxt;
         soft_r <= soft_nxt;
         sw_r <= sw_nxt;
      end
   end

   assign o_acc_type = type_r;
   assign o_adc_reg = adc_r;
   assign o_sw_close = sw_r;
   assign o_adc_start = (st_r == ST_MEAS) & ~(i_vbus_cmp & i_chg_det);
   assign o_i2c_en = i2c_ok & rst_b;
   assign o_det_en = pwr_ok & rst_b;
   assign o_supply_bat = i_bat_ok;
   assign o_irq_out_n = ~mask_r;
   assign o_soft_rst = soft_r;

   // helpers: cycles a switch change has waited
   logic [31:0] pend_cnt_r, pend_cnt_nxt, open_cnt_r, open_cnt_nxt;
   logic open_pend;
   assign open_pend = |(sw_r & ~tgt) & ~hard_clr;
   always_comb begin
      pend_cnt_nxt = 32'h0;
      open_cnt_nxt = 32'h0;
      if (tgt != sw_r && sw_nxt == sw_r && !hard_clr) pend_cnt_nxt = pend_cnt_r + 32'h1;
      if (open_pend && sw_nxt == sw_r) open_cnt_nxt = open_cnt_r + 32'h1;
   end
   always_ff @(posedge i_mclk or negedge rst_b) begin
      if (!rst_b) begin
         pend_cnt_r <= 32'h0;
         open_cnt_r <= 32'h0;
      end else begin
         pend_cnt_r <= pend_cnt_nxt;
         open_cnt_r <= open_cnt_nxt;
      end
   end

   // checks
   stby_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_STBY && !attach && !hard_clr) |=> st_r == ST_STBY)
      else $error("left standby without attach");
   stby_wake_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_STBY && attach && !hard_clr) |=> st_r == ST_MEAS)
      else $error("attach not seen");
   type_rec_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_MEAS && attach && i_vbus_cmp && i_chg_det && !hard_clr)
      |=> o_acc_type == TY_CHG) else $error("charger type not stored");
   type_keep_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_ATT && attach && !hard_clr) |=> $stable(o_acc_type))
      else $error("stored type changed");
   detach_clr_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_ATT && !attach && !hard_clr)
      |=> (st_r == ST_STBY && o_acc_type == TY_NONE && o_adc_reg == ADC_NONE))
      else $error("detach not cleared");
   auto_sw_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (!mode_r && sw_r != adsc_sw_of(type_r)) |-> tgt == adsc_sw_of(type_r))
      else $error("auto target wrong");
   man_sw_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (i2c_ok && i_man_wr && i_man_mode && !hard_clr) |=> tgt == $past(i_man_sw))
      else $error("manual target wrong");
   man_lock_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (!i2c_ok && !hard_clr) |=> ($stable(mode_r) && $stable(man_r)))
      else $error("write taken without i2c");
   i2c_gate_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      !i_io_rail_supply |-> !o_i2c_en) else $error("i2c on without io rail");
   i2c_on_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (i_io_rail_supply && i_bat_ok) |-> o_i2c_en) else $error("i2c off with supplies");

   // switch delays against the on and off times
   open_time_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      open_pend |-> open_cnt_r < 32'(TOFF_CYC))
      else $error("switch open too slow");
   close_time_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (tgt != sw_r && !hard_clr) |-> pend_cnt_r < 32'(TON_CYC))
      else $error("switch close too slow");
   sw_early_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (sw_nxt != sw_r && !hard_clr) |-> pend_cnt_r >= 32'(TOFF_CYC - 1))
      else $error("switch moved too early");
   close_early_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (sw_nxt != sw_r && !open_pend && !hard_clr) |-> pend_cnt_r == 32'(TON_CYC - 1))
      else $error("switch closed at wrong time");

   // supplies, resets and measurement
   pdn_rst_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (!i_bat_ok && !i_bus_ok) |=> (st_r == ST_STBY && o_sw_close == 2'h0))
      else $error("no power-down reset");
   det_off_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (!i_bat_ok && !i_bus_ok) |-> !o_det_en) else $error("detection on without supply");
   irq_hold_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (soft_r) |=> !o_irq_out_n) else $error("irq not held after soft reset");
   irq_clr_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (i2c_ok && i_mask_clr && !hard_clr) |=> o_irq_out_n)
      else $error("irq mask not cleared");
   soft_cnt_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      soft_r |-> sr_cnt_r == 32'(SWRST_CYCLES))
      else $error("soft reset count wrong");
   det_en_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (i_bat_ok || i_bus_ok) |-> o_det_en) else $error("detection disabled");
   sup_bat_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      i_bat_ok |-> o_supply_bat) else $error("battery not used as supply");
   adc_req_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_MEAS && !i_vbus_cmp) |-> o_adc_start)
      else $error("adc not requested");
   chg_skip_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_MEAS && i_vbus_cmp && i_chg_det) |-> !o_adc_start)
      else $error("adc requested for charger");
   cls_a: assert property (@(posedge i_mclk) disable iff (!rst_b)
      (st_r == ST_MEAS && attach && i_adc_valid && !(i_vbus_cmp && i_chg_det) && !hard_clr)
      |=> st_r == ST_ATT) else $error("no classification");

   // coverage of main scenarios
   cov_attach_c: cover property (@(posedge i_mclk) disable iff (!rst_b)
      st_r == ST_MEAS ##1 st_r == ST_ATT);
   cov_manual_c: cover property (@(posedge i_mclk) disable iff (!rst_b)
      mode_r && sw_r == SW_UART);
   cov_soft_c: cover property (@(posedge i_mclk) disable iff (!rst_b) soft_r);
   cov_detach_c: cover property (@(posedge i_mclk) disable iff (!rst_b)
      st_r == ST_ATT ##1 st_r == ST_STBY);
   cov_charger_c: cover property (@(posedge i_mclk) disable iff (!rst_b)
      st_r == ST_MEAS && i_vbus_cmp && i_chg_det);
endmodule // adsc_ctrl

// >>> verilog/adsc_pkg.sv
// package for the accessory detect and switch control block
// assumes a single 40 MHz clock domain
package adsc_pkg;
   localparam int CLK_MHZ = 40;
   localparam int ADC_W = 5;
   localparam int TYPE_W = 4;
   localparam int T_ON_NS = 95000;
   localparam int T_OFF_NS = 3500;
   localparam int T_SWRST_MS = 30;
   localparam int TON_CYC = T_ON_NS * CLK_MHZ / 1000;
   localparam int TOFF_CYC = T_OFF_NS * CLK_MHZ / 1000;
   localparam int SWRST_CYC = T_SWRST_MS * 1000 * CLK_MHZ + 1;
   localparam logic [ADC_W-1:0] ADC_NONE = 5'h1F;
   localparam logic [ADC_W-1:0] ADC_UART = 5'h16;
   localparam logic [ADC_W-1:0] ADC_PPD = 5'h14;
   localparam logic [ADC_W-1:0] ADC_FUSB0 = 5'h18;
   localparam logic [ADC_W-1:0] ADC_FUSB1 = 5'h19;
   localparam logic [ADC_W-1:0] ADC_FUART0 = 5'h1C;
   localparam logic [ADC_W-1:0] ADC_FUART1 = 5'h1D;
   localparam logic [ADC_W-1:0] ADC_OTG = 5'h00;
   localparam logic [TYPE_W-1:0] TY_NONE = 4'h0;
   localparam logic [TYPE_W-1:0] TY_USB = 4'h1;
   localparam logic [TYPE_W-1:0] TY_CHG = 4'h2;
   localparam logic [TYPE_W-1:0] TY_UART = 4'h3;
   localparam logic [TYPE_W-1:0] TY_FUSB = 4'h4;
   localparam logic [TYPE_W-1:0] TY_FUART = 4'h5;
   localparam logic [TYPE_W-1:0] TY_OTG = 4'h6;
   localparam logic [TYPE_W-1:0] TY_OTHER = 4'h7;
   localparam logic [1:0] SW_USB = 2'h1;
   localparam logic [1:0] SW_UART = 2'h2;
   typedef enum logic [2:0] {
      ST_STBY = 3'h1,
      ST_MEAS = 3'h2,
      ST_ATT = 3'h4
   } adsc_state_t;
endpackage

// >>> tb/adsc_host_model.sv
// host model: decoded i2c writes and i2c line levels
// assumes tasks are called just after a rising clock edge
`timescale 1ns/1ps
module adsc_host_model (
   input wire logic i_mclk,
   output logic o_scl,
   output logic o_sda,
   output logic o_ack,
   output logic o_wr,
   output logic o_mode,
   output logic [1:0] o_sw,
   output logic o_mask_clr
);
   initial begin
      {o_scl, o_sda} = 2'h3;
      {o_ack, o_wr, o_mode, o_sw, o_mask_clr} = 6'h00;
   end
   // manual setting write, ack in the same cycle
   task automatic wr(input logic m, input logic [1:0] s);
      {o_wr, o_ack, o_mode, o_sw} = {2'h3, m, s};
      @(posedge i_mclk) #1;
      {o_wr, o_ack, o_mode, o_sw} = {2'h0, ~m, ~s};
   endtask
   task automatic mask_clr;
      o_mask_clr = 1'b1;
      @(posedge i_mclk) #1;
      o_mask_clr = 1'b0;
   endtask
   // both lines low, then back to pull-up level
   task automatic hold(input int n);
      {o_scl, o_sda} = 2'h0;
      repeat (n) @(posedge i_mclk);
      #1;
      {o_scl, o_sda} = 2'h3;
   endtask
endmodule // adsc_host_model

// >>> tb/tb.sv
// self-checking bench for adsc_ctrl with the host model
// assumes 40 MHz clock and a shortened soft reset count
`timescale 1ns/1ps
module tb;
   import adsc_pkg::*;
   localparam int SWR = 50;
   logic i_mclk = 1'b0;
   logic rst_b = 1'b0;
   logic bat = 1'b1, bus = 1'b1, io = 1'b1, seen = 1'b0;
   logic vbus = 1'b0, id = 1'b0, chg = 1'b0, av = 1'b0;
   logic [ADC_W-1:0] code = ADC_NONE;
   logic scl, sda, ack, wr, mode, mclr, i2c, det, sbat, irq, srst, ast;
   logic [1:0] msw, sw;
   logic [TYPE_W-1:0] typ;
   logic [ADC_W-1:0] adcr;
   int miscompares = 0, n_compared = 0, cyc = 0;
   always #12.5 i_mclk = ~i_mclk;
   adsc_host_model adsc_host_model_i (.i_mclk(i_mclk), .o_scl(scl), .o_sda(sda),
      .o_ack(ack), .o_wr(wr), .o_mode(mode), .o_sw(msw), .o_mask_clr(mclr));
   adsc_ctrl #(.SWRST_CYCLES(SWR)) adsc_ctrl_i (.i_mclk(i_mclk), .i_rst_b(rst_b),
      .i_bat_ok(bat), .i_bus_ok(bus), .i_io_rail_supply(io), .i_vbus_cmp(vbus),
      .i_id_cmp(id), .i_chg_det(chg), .i_adc_valid(av), .i_adc_code(code), .i_scl(scl),
      .i_sda(sda), .i_ack(ack), .i_man_wr(wr), .i_man_mode(mode), .i_man_sw(msw),
      .i_mask_clr(mclr), .o_acc_type(typ), .o_adc_reg(adcr), .o_sw_close(sw),
      .o_adc_start(ast), .o_i2c_en(i2c), .o_det_en(det), .o_supply_bat(sbat),
      .o_irq_out_n(irq), .o_soft_rst(srst));
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task automatic summarize;
      $display("compared %0d miscompared %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cyc++;
      if (srst === 1'b1) seen = 1'b1;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic adc(input logic [ADC_W-1:0] c);
      {av, code} = {1'b1, c};
      tick(1);
      {av, code} = {1'b0, ~c};
      tick(1);
   endtask
   task automatic t_supply;
      for (int i = 0; i < 8; i++) begin
         {bat, bus, io} = i[2:0];
         tick(1);
         chk(det, bat | bus, "det");
         chk(sbat, bat, "sup");
         chk(i2c, io & bat, "i2c");
      end
      tick(2);
      $display("test supply done");
   endtask
   task automatic t_usb;
      vbus = 1'b1;
      tick(2);
      chk(ast, 1'b1, "meas");
      adc(ADC_NONE);
      chk(typ, TY_USB, "type");
      chk(adcr, ADC_NONE, "adc");
      tick(3700);
      chk(sw, 2'h0, "early");
      tick(200);
      chk(sw, SW_USB, "sw");
      $display("test usb done");
   endtask
   task automatic t_manual;
      adsc_host_model_i.wr(1'b1, SW_UART);
      tick(130);
      chk(sw, SW_USB, "hold");
      tick(20);
      chk(sw, SW_UART, "man");
      adc(ADC_FUSB0);
      tick(200);
      chk(sw, SW_UART, "keep");
      adsc_host_model_i.wr(1'b0, 2'h0);
      tick(200);
      chk(sw, SW_USB, "auto");
      io = 1'b0;
      adsc_host_model_i.wr(1'b1, 2'h0);
      tick(200);
      chk(sw, SW_USB, "off");
      io = 1'b1;
      $display("test manual done");
   endtask
   task automatic t_uart;
      vbus = 1'b0;
      tick(5);
      chk(typ, TY_NONE, "stby");
      tick(200);
      chk(sw, 2'h0, "open");
      id = 1'b1;
      tick(2);
      chk(ast, 1'b1, "meas");
      adc(ADC_UART);
      chk(typ, TY_UART, "type");
      chk(adcr, ADC_UART, "adc");
      tick(3900);
      chk(sw, SW_UART, "sw");
      $display("test uart done");
   endtask
   task automatic t_swrst;
      id = 1'b0;
      adsc_host_model_i.hold(SWR + 5);
      tick(20);
      chk(seen, 1'b1, "srst");
      chk(typ, TY_NONE, "clr");
      chk(irq, 1'b0, "irq");
      adsc_host_model_i.mask_clr();
      tick(2);
      chk(irq, 1'b1, "unm");
      $display("test soft reset done");
   endtask
   task automatic id_one(input logic [ADC_W-1:0] c, input logic [TYPE_W-1:0] t);
      id = 1'b1;
      tick(2);
      adc(c);
      chk(typ, t, "code");
      chk(adcr, c, "code reg");
      id = 1'b0;
      tick(2);
      chk(typ, TY_NONE, "gone");
   endtask
   task automatic t_types;
      {vbus, chg} = 2'h3;
      tick(1);
      chk(ast, 1'b0, "no adc");
      tick(1);
      chk(typ, TY_CHG, "chg");
      chk(adcr, ADC_NONE, "chg adc");
      tick(200);
      chk(sw, 2'h0, "chg sw");
      {bat, bus} = 2'h0;
      tick(1);
      chk(typ, TY_NONE, "pdn");
      {bat, bus, vbus, chg} = 4'hC;
      tick(2);
      id_one(ADC_OTG, TY_OTG);
      id_one(ADC_PPD, TY_UART);
      id_one(ADC_FUSB1, TY_FUSB);
      id_one(ADC_FUART0, TY_FUART);
      id_one(ADC_FUART1, TY_FUART);
      id_one(5'h0E, TY_OTHER);
      $display("test types done");
   endtask
   initial begin
      tick(5);
      rst_b = 1'b1;
      tick(3);
      chk(typ, TY_NONE, "rst");
      chk({irq, sw}, 3'h4, "rst");
      t_supply();
      t_usb();
      t_manual();
      t_uart();
      t_swrst();
      t_types();
      summarize();
   end
endmodule // tb
